// ### rtl/afe_serial_port.sv
// Purpose: pin-level host serial port of a modem front end, port master
// Assumes: system clock 40 MHz; bit clock is system clock / 18; pins synchronous
// Notes: frame contents supplied and returned as 16-bit words on user ports
`include "afe_port_regs.svh"
module afe_serial_port (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in, // Pad pull-up keeps it high when open
  // Straps
  input wire logic framing_strap_in,
  input wire logic bitclk_gating_strap_in,
  // Serial link pins
  output logic bitclk_out,
  output logic frame_sync_n_out,
  output logic serial_out_to_host_out,
  input wire logic serial_in_from_host_in,
  // Word interface to the core
  input wire logic [15:0] tx_word_in,
  output logic tx_word_taken_out,
  output logic [15:0] rx_word_out,
  output logic rx_word_valid_out,
  output logic early_mode_out,
  // General purpose pins, software controlled
  input wire logic [`GPIO_WIDTH-1:0] gpio_dir_in,
  input wire logic [`GPIO_WIDTH-1:0] gpio_value_in,
  input wire logic gpio_write_in,
  output logic [`GPIO_WIDTH-1:0] gpio_pin_out,
  output logic [`GPIO_WIDTH-1:0] gpio_pin_oe_n_out,
  input wire logic [`GPIO_WIDTH-1:0] gpio_pin_in,
  output logic [`GPIO_WIDTH-1:0] gpio_read_out
);
  // ==========================================
  // State record
  typedef struct packed {
    afe_port_pkg::framing_t mode;
    afe_port_pkg::frame_state_t fstate;
    logic [8:0] bit_pos;
    logic sclk;
    logic fs_n;
    logic sdo;
    logic [15:0] tx_shift;
    logic [15:0] rx_shift;
    logic [3:0] rx_count;
    logic [15:0] rx_word;
    logic rx_valid;
    logic taken;
    logic [`GPIO_WIDTH-1:0] gpio_dir;
    logic [`GPIO_WIDTH-1:0] gpio_val;
    logic [`GPIO_WIDTH-1:0] gpio_rd;
  } port_state_t;
  port_state_t st;
  port_state_t next_st;
  logic rise;
  logic fall;
  // ==========================================
  // Edge enables from the divide-by-18 counter
  bitclk_divider u_div (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .rise_out(rise),
    .fall_out(fall)
  );
  // Gated mode stops the clock once 32 bits have passed
  function automatic logic clock_enabled(input logic gated, input logic [8:0] pos);
    clock_enabled = !gated || (pos < `GATED_CLOCKS);
  endfunction : clock_enabled
  // ==========================================
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rx_valid = 1'b0;
    next_st.taken = 1'b0;
    // Strap followed only while reset is low; frozen afterwards
    if (!rst_n_in) begin
      next_st.mode = framing_strap_in ? afe_port_pkg::early_framing
                                      : afe_port_pkg::late_framing;
    end
    if (gpio_write_in) begin
      next_st.gpio_dir = gpio_dir_in;
      next_st.gpio_val = gpio_value_in;
    end
    next_st.gpio_rd = gpio_pin_in;
    if (rise) begin
      next_st.bit_pos = (st.bit_pos == `BITS_PER_FRAME - 9'h001) ? 9'h000
                                                                : st.bit_pos + 9'h001;
      // Gating judged on the new position, so the sync edge itself gets a pulse
      next_st.sclk = clock_enabled(!bitclk_gating_strap_in, next_st.bit_pos);
      case (st.fstate)
        afe_port_pkg::st_idle: begin
          if (st.bit_pos == `BITS_PER_FRAME - 9'h001) begin
            // Early pulse sits one clock before data; late covers the word
            next_st.fs_n = 1'b0;
            next_st.tx_shift = tx_word_in;
            next_st.taken = 1'b1;
            if (st.mode == afe_port_pkg::late_framing) begin
              next_st.fstate = afe_port_pkg::st_word;
              next_st.sdo = tx_word_in[`LAST_BIT];
              next_st.tx_shift = {tx_word_in[14:0], 1'b0};
            end else begin
              next_st.fstate = afe_port_pkg::st_tail;
            end
          end
        end
        afe_port_pkg::st_tail: begin
          // Early frame: sync drops off as the first bit goes out
          next_st.fs_n = 1'b1;
          next_st.sdo = st.tx_shift[`LAST_BIT];
          next_st.tx_shift = {st.tx_shift[14:0], 1'b0};
          next_st.fstate = afe_port_pkg::st_word;
        end
        afe_port_pkg::st_word: begin
          // Early frames start one clock later, so their last bit ends one clock later
          if ((st.mode == afe_port_pkg::late_framing && st.bit_pos[4:0] == `WORD_BITS - 5'h01) ||
              (st.mode == afe_port_pkg::early_framing && st.bit_pos[4:0] == `WORD_BITS)) begin
            next_st.fs_n = 1'b1;
            next_st.sdo = 1'b0;
            next_st.fstate = afe_port_pkg::st_idle;
          end else begin
            next_st.sdo = st.tx_shift[`LAST_BIT];
            next_st.tx_shift = {st.tx_shift[14:0], 1'b0};
          end
        end
        default: begin
          next_st.fstate = afe_port_pkg::st_idle;
          next_st.fs_n = 1'b1;
        end
      endcase
    end
    if (fall) begin
      next_st.sclk = 1'b0;
      // Host data taken on the falling edge inside the word
      if (st.fstate == afe_port_pkg::st_word) begin
        next_st.rx_shift = {st.rx_shift[14:0], serial_in_from_host_in};
        next_st.rx_count = st.rx_count + 4'h1;
        if (st.rx_count == `LAST_BIT) begin
          next_st.rx_word = {st.rx_shift[14:0], serial_in_from_host_in};
          next_st.rx_valid = 1'b1;
        end
      end else begin
        next_st.rx_count = 4'h0;
      end
    end
  end
  // ==========================================
  // State register; reset loads constants only, mode follows strap via next_st
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.mode <= next_st.mode;
      st.fs_n <= 1'b1;
      st.bit_pos <= `BITS_PER_FRAME - 9'h002;
      st.gpio_dir <= `GPIO_DIR_RESET;
      st.gpio_val <= `GPIO_OUT_RESET;
    end else begin
      st <= next_st;
    end
  end
  // ==========================================
  // Outputs, all from flip-flops, the handshake included
  assign bitclk_out = st.sclk;
  assign frame_sync_n_out = st.fs_n;
  assign serial_out_to_host_out = st.sdo;
  assign rx_word_out = st.rx_word;
  assign rx_word_valid_out = st.rx_valid;
  assign tx_word_taken_out = st.taken;
  assign early_mode_out = (st.mode == afe_port_pkg::early_framing);
  // Direction bit high means output; enable is active low
  assign gpio_pin_out = st.gpio_val;
  assign gpio_pin_oe_n_out = ~st.gpio_dir;
  assign gpio_read_out = st.gpio_rd;
endmodule : afe_serial_port

// ### rtl/afe_port_regs.svh
// Purpose: named constants for the host serial port pin block
// Assumes: 40 MHz system clock, one clock domain
// Notes: counts are in system clock cycles or bit-clock periods
`ifndef AFE_PORT_REGS_SVH
`define AFE_PORT_REGS_SVH
// ==========================================
// Bit clock divider
`define BITCLK_DIV 5'h12
`define BITCLK_HALF 5'h09
// ==========================================
// Frame shape
`define BITS_PER_FRAME 9'h100
`define WORD_BITS 5'h10
`define GATED_CLOCKS 9'h020
`define LAST_BIT 4'hF
// ==========================================
// General purpose pins
`define GPIO_WIDTH 8
`define GPIO_DIR_RESET 8'h00
`define GPIO_OUT_RESET 8'h00
`endif

// ### rtl/afe_port_pkg.sv
// Purpose: types for the host serial port pin block
// Assumes: included constants header carries all numbers
// Notes: framing mode and frame state are enums
package afe_port_pkg;
  // ==========================================
  // Framing style latched at reset
  typedef enum logic [0:0] {
    late_framing = 1'b0,
    early_framing = 1'b1
  } framing_t;
  // ==========================================
  // Frame position states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_word = 2'b01,
    st_tail = 2'b10
  } frame_state_t;
endpackage : afe_port_pkg

// ### rtl/bitclk_divider.sv
// Purpose: divide the system clock by 18 into bit-clock edge enables
// Assumes: synchronous active-low reset
// Notes: emits one-cycle rise and fall enables, no derived clock domain
`include "afe_port_regs.svh"
module bitclk_divider (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Edge enables
  output logic rise_out,
  output logic fall_out
);
  typedef struct packed {
    logic [4:0] count;
  } div_state_t;
  div_state_t st;
  div_state_t next_st;
  // ==========================================
  // Counter wraps every 18 cycles
  always_comb begin
    next_st = st;
    if (st.count == `BITCLK_DIV - 5'h01) begin
      next_st.count = 5'h00;
    end else begin
      next_st.count = st.count + 5'h01;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // Rise at count zero, fall half a period later
  assign rise_out = (st.count == 5'h00);
  assign fall_out = (st.count == `BITCLK_HALF);
endmodule : bitclk_divider

// ### verif/afe_serial_port_chk.sv
// Purpose: pin timing checks for afe_serial_port
// Assumes: one clock domain, sync active-low reset
// Notes: small counters size frame and pulse lengths
module afe_serial_port_chk (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Watched pins
  input wire logic framing_strap_in,
  input wire logic bitclk_out,
  input wire logic frame_sync_n_out,
  input wire logic early_mode_out,
  input wire logic [7:0] gpio_dir_in,
  input wire logic [7:0] gpio_value_in,
  input wire logic gpio_write_in,
  input wire logic [7:0] gpio_pin_out,
  input wire logic [7:0] gpio_pin_oe_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // ====
  // Cycle counts; seen skips the first frame
  logic [12:0] cyc;
  logic [8:0] low;
  logic seen;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cyc <= 13'h0;
      low <= 9'h0;
      seen <= 1'b0;
    end else begin
      cyc <= $fell(frame_sync_n_out) ? 13'h0 : cyc + 13'h1;
      low <= frame_sync_n_out ? 9'h0 : low + 9'h1;
      seen <= seen | $fell(frame_sync_n_out);
    end
  end
  // ====
  // Properties
  sequence s_high9;
    bitclk_out [*8] ##1 bitclk_out ##1 !bitclk_out;
  endsequence
  property p_reset_idle;
    disable iff (1'b0) !rst_n_in |=> !bitclk_out && frame_sync_n_out && &gpio_pin_oe_n_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("pins not idle in reset");
  property p_mode_latch;
    disable iff (1'b0) $rose(rst_n_in) |-> early_mode_out == $past(framing_strap_in);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");
  property p_mode_hold;
    $past(rst_n_in) |-> $stable(early_mode_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_high;
    $rose(bitclk_out) |-> s_high9;
  endproperty
  a_high: assert property (p_high) else $error("bit clock high not 9");
  property p_fs_on_rise;
    $changed(frame_sync_n_out) |-> $rose(bitclk_out);
  endproperty
  a_fs_on_rise: assert property (p_fs_on_rise) else $error("sync off rise");
  property p_period;
    $fell(frame_sync_n_out) && seen |-> cyc == 13'h11FF;
  endproperty
  a_period: assert property (p_period) else $error("frame period");
  property p_fs_width;
    $rose(frame_sync_n_out) |-> low == (early_mode_out ? 9'h012 : 9'h120);
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("sync width");
  property p_gpio;
    gpio_write_in |=> gpio_pin_out == $past(gpio_value_in)
      && gpio_pin_oe_n_out == ~$past(gpio_dir_in);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio write");
endmodule : afe_serial_port_chk
bind afe_serial_port afe_serial_port_chk u_chk (.clk_sys_in, .rst_n_in, .framing_strap_in,
  .bitclk_out, .frame_sync_n_out, .early_mode_out, .gpio_dir_in, .gpio_value_in,
  .gpio_write_in, .gpio_pin_out, .gpio_pin_oe_n_out);

// ### verif/host_port_model.sv
// Purpose: host serial port facing the device pins
// Assumes: pins sampled on the system clock
// Notes: idle data toggles so a stale bit never passes
module host_port_model (
  // Clock
  input wire logic clk_sys_in,
  // Device pins and host words
  input wire logic bitclk_in,
  input wire logic frame_sync_n_in,
  input wire logic data_in,
  input wire logic early_in,
  input wire logic [15:0] word_in,
  output logic data_out,
  output logic [15:0] word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bc_q = 1'b0;
  logic fs_q = 1'b1;
  logic [8:0] pos = 9'h100;
  int b;
  initial data_out = 1'b0;
  // Drive after bit-clock rise, sample on fall
  always @(posedge clk_sys_in) begin
    b = int'(pos) - int'(early_in);
    bc_q <= bitclk_in;
    if (bitclk_in && !bc_q) begin
      fs_q <= frame_sync_n_in;
      pos <= (fs_q && !frame_sync_n_in) ? 9'h0 : pos + 9'h1;
      b = (fs_q && !frame_sync_n_in) ? -int'(early_in) : b + 1;
      data_out <= (b >= 0 && b < 16) ? word_in[15 - b] : !data_out;
    end
    if (!bitclk_in && bc_q && b >= 0 && b < 16) begin
      word_out[15 - b] <= data_in;
    end
  end
endmodule : host_port_model

// ### verif/tb_afe_serial_port.sv
// Purpose: self-checking bench for afe_serial_port
// Assumes: 40 MHz clock, seeded random words and pins
// Notes: each strap pair runs three frames against the host model
module tb_afe_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
`define CHECK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
  int failures = 0, check_count = 0, seed = 32'h8CCFA907, rises = 0, last = 0, cyc = 0;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, framing_strap_in = 1'b1, bc_q = 1'b0;
  logic bitclk_gating_strap_in = 1'b1, serial_in_from_host_in, gpio_write_in = 1'b0;
  logic [15:0] tx_word_in = 16'h0, rx_word_out, host_tx = 16'h0, host_rx;
  logic bitclk_out, frame_sync_n_out, serial_out_to_host_out, tx_word_taken_out;
  logic rx_word_valid_out, early_mode_out;
  logic [7:0] gpio_dir_in = 8'h0, gpio_value_in = 8'h0, gpio_pin_out, gpio_pin_oe_n_out;
  logic [7:0] gpio_pin_in = 8'h0, gpio_read_out;
  afe_serial_port uut (.clk_sys_in, .rst_n_in, .framing_strap_in, .bitclk_gating_strap_in,
    .bitclk_out, .frame_sync_n_out, .serial_out_to_host_out, .serial_in_from_host_in,
    .tx_word_in, .tx_word_taken_out, .rx_word_out, .rx_word_valid_out, .early_mode_out,
    .gpio_dir_in, .gpio_value_in, .gpio_write_in, .gpio_pin_out, .gpio_pin_oe_n_out,
    .gpio_pin_in, .gpio_read_out);
  host_port_model host (.clk_sys_in, .bitclk_in(bitclk_out), .frame_sync_n_in(frame_sync_n_out),
    .data_in(serial_out_to_host_out), .early_in(early_mode_out), .word_in(host_tx),
    .data_out(serial_in_from_host_in), .word_out(host_rx));
  always #12.5 clk_sys_in = ~clk_sys_in;
  // Free cycle and bit-clock rise counts
  always @(posedge clk_sys_in) begin
    cyc++;
    bc_q <= bitclk_out;
    if (bitclk_out && !bc_q) rises++;
  end
  function automatic int exp_rises(input logic g);
    return g ? 256 : 32;
  endfunction : exp_rises
  task automatic complete_run();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // Bounded wait: 0 for word taken, 1 for word received
  task automatic wait_sig(input int which);
    for (int n = 0; n < 6000; n++) begin
      @(posedge clk_sys_in);
      #1;
      if ((which == 0 ? tx_word_taken_out : rx_word_valid_out) === 1'b1) return;
    end
    failures++;
    complete_run();
  endtask : wait_sig
  task automatic run_mode(input logic fs_s, input logic g_s);
    logic [15:0] sent;
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    framing_strap_in <= fs_s;
    bitclk_gating_strap_in <= g_s;
    repeat (20) @(posedge clk_sys_in);
    #1;
    `CHECK({bitclk_out, frame_sync_n_out, gpio_pin_oe_n_out}, 10'h1FF)
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    framing_strap_in <= !fs_s;
    for (int f = 0; f < 3; f++) begin
      wait_sig(0);
      sent = tx_word_in;
      if (f > 0) `CHECK(cyc - last, 4608)
      if (f > 0) `CHECK(rises, exp_rises(g_s))
      last = cyc;
      rises = 0;
      wait_sig(1);
      `CHECK(rx_word_out, host_tx)
      @(posedge clk_sys_in);
      #1;
      `CHECK(host_rx, sent)
      `CHECK(early_mode_out, fs_s)
      @(posedge clk_sys_in);
      tx_word_in <= (f == 0) ? 16'h8001 : 16'($random(seed));
      host_tx <= (f == 1) ? 16'h7FFE : 16'($random(seed));
    end
  endtask : run_mode
  // Random pin writes, one edge to land
  task automatic gpio_pass();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_in);
      gpio_dir_in <= (i == 0) ? 8'hFF : 8'($random(seed));
      gpio_value_in <= 8'($random(seed));
      gpio_pin_in <= 8'($random(seed));
      gpio_write_in <= 1'b1;
      @(posedge clk_sys_in);
      gpio_write_in <= 1'b0;
      #1;
      `CHECK({gpio_pin_oe_n_out, gpio_pin_out}, {~gpio_dir_in, gpio_value_in})
      `CHECK(gpio_read_out, gpio_pin_in)
    end
  endtask : gpio_pass
  // Every strap pair, each followed by a pin pass
  initial begin
    for (int m = 0; m < 4; m++) begin
      run_mode(m[0], m[1]);
      gpio_pass();
    end
    complete_run();
  end
endmodule : tb_afe_serial_port
